// File: design/pcs_ctl_regs.sv
// control and status register bank of a 10/100 transceiver
// assumes the management frame engine hands over one-cycle read/write strobes on clk_in,
// negotiation and mode-control inputs come from logic on clk_in, tx_en_in is a raw pin
//
// Function
// R1 - writing 1 restarts negotiation; bit self-clears once restart is acknowledged
// R2 - duplex choice 1 full, 0 half; ignored while negotiation is enabled
// R3 - collision test: COL follows TX_EN assertion within 512 bit times
// R4 - collision test: COL drops within 4 bit times after TX_EN drops
// R5 - status register is read-only; writes change nothing
// R6 - four-pair ability reads 0; bits 14 to 11 always read 1
// R7 - status bit 6 mirrors mode control bit 1, default 1
// R8 - controller sends 32 preamble bits before first transaction after reset
// R9 - controller leaves one idle bit between transactions
// R10 - status bit 5 shows negotiation complete, resets to 0
// R11 - status bit 4 set when partner ability remote-fault bit is 1
// R12 - remote fault bit latches high until status register is read
// R13 - control bit 12 enables negotiation, default 1
// R14 - reserved control bits 6..0 and status bits 10..7 read 0
`timescale 1ns/100ps
module pcs_ctl_regs (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire pcs_pkg::pcs_req_s req_in,
    input wire logic neg_done_in,
    input wire logic partner_fault_in,
    input wire logic mode_pre_supp_in,
    input wire logic restart_ack_in,
    input wire logic negotiated_full_in,
    input wire logic tx_en_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic renegotiate_out,
    output logic aneg_enable_out,
    output logic full_duplex_out,
    output logic col_out
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // frame engine sequencing (preamble, idle bits) is upstream of this bank  R8 R9
    wire ctl_hit = (req_in.addr == pcs_pkg::BASIC_CONTROL_IDX);
    wire sts_hit = (req_in.addr == pcs_pkg::BASIC_STATUS_IDX);
    wire ctl_wr = req_in.wr & ctl_hit;
    wire sts_rd = req_in.rd & sts_hit;
    wire reneg_set = ctl_wr & req_in.wdata[pcs_pkg::CTL_RENEG_BIT];

    logic renegotiate_request_r;
    logic aneg_enable_r;
    logic duplex_choice_r;
    logic collision_test_enable_r;
    logic negotiation_done_r;
    logic remote_fault_flag_r;
    logic preamble_suppression_ok_r;
    logic tx_en_meta_r;
    logic tx_en_sync_r;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // writes to any other index, status included, fall through untouched  R5
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            aneg_enable_r <= pcs_pkg::CTL_ANEG_EN_RST;
            duplex_choice_r <= pcs_pkg::CTL_DUPLEX_RST;
            collision_test_enable_r <= pcs_pkg::CTL_COLTEST_RST;
        end else if (ctl_wr) begin
            aneg_enable_r <= req_in.wdata[pcs_pkg::CTL_ANEG_EN_BIT]; // R13
            duplex_choice_r <= req_in.wdata[pcs_pkg::CTL_DUPLEX_BIT];
            collision_test_enable_r <= req_in.wdata[pcs_pkg::CTL_COLTEST_BIT];
        end
    end

    // restart request holds until the negotiation engine takes it; a new write wins over the ack
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            renegotiate_request_r <= pcs_pkg::CTL_RENEG_RST;
        end else if (reneg_set) begin
            renegotiate_request_r <= 1'b1; // R1
        end else if (restart_ack_in) begin
            renegotiate_request_r <= 1'b0; // R1
        end
    end

    // ------------------------------------------------------------
    // status capture
    // ------------------------------------------------------------
    // fault set wins over the clear-on-read so an event in the read cycle is not lost
    wire fault_nxt = partner_fault_in | (remote_fault_flag_r & ~sts_rd);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            negotiation_done_r <= pcs_pkg::STS_NEG_DONE_RST;
            remote_fault_flag_r <= pcs_pkg::STS_REM_FAULT_RST;
            preamble_suppression_ok_r <= pcs_pkg::STS_PRE_SUPP_RST;
        end else begin
            negotiation_done_r <= neg_done_in; // R10
            remote_fault_flag_r <= fault_nxt; // R11 R12
            preamble_suppression_ok_r <= mode_pre_supp_in; // R7
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // unlisted control bits belong to other logic and read 0 here
    wire [15:0] ctl_word = {3'h0, aneg_enable_r, 2'h0, renegotiate_request_r, duplex_choice_r,
                            collision_test_enable_r, 7'h00}; // R14
    wire [15:0] sts_word = {pcs_pkg::STS_ABILITY_VAL, 4'h0, preamble_suppression_ok_r,
                            negotiation_done_r, remote_fault_flag_r, 4'h0}; // R6 R14
    wire [15:0] rd_mux = ctl_hit ? ctl_word : (sts_hit ? sts_word : 16'h0000);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 16'h0000;
            rvalid_out <= 1'b0;
        end else begin
            rdata_out <= req_in.rd ? rd_mux : rdata_out;
            rvalid_out <= req_in.rd;
        end
    end

    // ------------------------------------------------------------
    // outputs to the datapath
    // ------------------------------------------------------------
    // manual duplex is only a fallback; the negotiated result rules while negotiation is on
    wire duplex_sel = aneg_enable_r ? negotiated_full_in : duplex_choice_r; // R2

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            renegotiate_out <= 1'b0;
            aneg_enable_out <= pcs_pkg::CTL_ANEG_EN_RST;
            full_duplex_out <= 1'b0;
        end else begin
            renegotiate_out <= renegotiate_request_r;
            aneg_enable_out <= aneg_enable_r;
            full_duplex_out <= duplex_sel;
        end
    end

    // ------------------------------------------------------------
    // collision test
    // ------------------------------------------------------------
    // tx_en is a pin; three cycles of latency (24 ns) sit far inside the 512 bit-time limit and inside the 4 bit-time one
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_en_meta_r <= 1'b0;
            tx_en_sync_r <= 1'b0;
            col_out <= 1'b0;
        end else begin
            tx_en_meta_r <= tx_en_in;
            tx_en_sync_r <= tx_en_meta_r;
            col_out <= collision_test_enable_r & tx_en_sync_r; // R3 R4
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    localparam int col_on_max = pcs_pkg::COL_ON_MAX_CYC;
    localparam int col_off_max = pcs_pkg::COL_OFF_MAX_CYC;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_coltest_tx;
        (collision_test_enable_r && tx_en_in)[*3];
    endsequence

    sequence s_tx_idle;
        (!tx_en_in)[*4];
    endsequence

    sequence s_fault_read;
        remote_fault_flag_r && sts_rd;
    endsequence

    a_restart_set: assert property (reneg_set |=> renegotiate_request_r ##1 renegotiate_out) // R1
        else $error("restart request not raised after write");
    a_restart_clear: assert property (restart_ack_in && !reneg_set && !ctl_wr |=> !renegotiate_request_r) // R1
        else $error("restart request not cleared after acknowledge");
    a_duplex_manual: assert property (!aneg_enable_r |=> full_duplex_out == $past(duplex_choice_r)) // R2
        else $error("manual duplex not applied");
    a_duplex_ignored: assert property (aneg_enable_r |=> full_duplex_out == $past(negotiated_full_in)) // R2
        else $error("duplex choice used while negotiation enabled");
    a_col_assert: assert property (s_coltest_tx |-> ##[0:col_on_max] col_out) // R3
        else $error("col not asserted in collision test");
    a_col_release: assert property (s_tx_idle |-> !col_out) // R4
        else $error("col not released after tx_en drop");
    a_col_normal: assert property (!collision_test_enable_r |=> !col_out) // R3
        else $error("col asserted outside collision test");
    a_sts_fixed: assert property (sts_rd |=> rvalid_out && rdata_out[15:7] == {pcs_pkg::STS_ABILITY_VAL, 4'h0}) // R6
        else $error("status fixed bits wrong");
    a_sts_fields: assert property (sts_rd |=> rdata_out[6:5] == // R7 R10
                                   $past({preamble_suppression_ok_r, negotiation_done_r}))
        else $error("status bits 6 or 5 wrong");
    a_fault_hold: assert property (remote_fault_flag_r && !sts_rd |=> remote_fault_flag_r) // R12
        else $error("remote fault dropped without read");
    a_fault_clear: assert property (sts_rd && !partner_fault_in |=> !remote_fault_flag_r) // R12
        else $error("remote fault not cleared by read");
    a_fault_set: assert property (partner_fault_in |=> remote_fault_flag_r) // R11
        else $error("remote fault not latched");
    a_fault_shown: assert property (s_fault_read |=> rdata_out[pcs_pkg::STS_REM_FAULT_BIT]) // R12
        else $error("latched remote fault not reported by read");
    a_ctl_rsvd: assert property (req_in.rd && ctl_hit |=> rdata_out[6:0] == 7'h00) // R14
        else $error("control reserved bits not zero");
    a_sts_ro: assert property (req_in.wr && sts_hit && !ctl_wr |=> // R5
                               $stable(aneg_enable_r) && $stable(duplex_choice_r))
        else $error("status write altered register state");

    // read path, write landing and reset state
    a_ctl_readback: assert property (req_in.rd && ctl_hit |=> rdata_out[15:7] == // R13 R14
                                     $past({3'h0, aneg_enable_r, 2'h0, renegotiate_request_r,
                                            duplex_choice_r, collision_test_enable_r}))
        else $error("control read data wrong");
    a_unmapped_zero: assert property (req_in.rd && !ctl_hit && !sts_hit |=> rdata_out == 16'h0000) // R14
        else $error("unmapped read not zero");
    a_restart_wins: assert property (reneg_set && restart_ack_in |=> renegotiate_request_r) // R1
        else $error("restart write lost to acknowledge");
    a_aneg_lands: assert property (ctl_wr |=> ##1 aneg_enable_out == // R13
                                   $past(req_in.wdata[pcs_pkg::CTL_ANEG_EN_BIT], 2))
        else $error("negotiation enable write not applied");
    // own clock and an empty disable so that the reset cycles themselves are checked
    a_reset_state: assert property (@(posedge clk_in) disable iff (1'b0) // R13
                                    srst_in |=> !rvalid_out && !col_out && !renegotiate_out && aneg_enable_out)
        else $error("outputs not at reset values");

endmodule // pcs_ctl_regs

// File: design/pcs_pkg.sv
// package for the transceiver control/status register bank
// assumes a single management clock domain and a synchronous reset
package pcs_pkg;

    // ------------------------------------------------------------
    // register indexes on the management interface
    // ------------------------------------------------------------
    localparam logic [4:0] BASIC_CONTROL_IDX = 5'h00;
    localparam logic [4:0] BASIC_STATUS_IDX = 5'h01;

    // ------------------------------------------------------------
    // basic_control field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_ANEG_EN_BIT = 12;
    localparam int CTL_RENEG_BIT = 9;
    localparam int CTL_DUPLEX_BIT = 8;
    localparam int CTL_COLTEST_BIT = 7;
    localparam logic CTL_ANEG_EN_RST = 1'b1;
    localparam logic CTL_RENEG_RST = 1'b0;
    localparam logic CTL_DUPLEX_RST = 1'b0;
    localparam logic CTL_COLTEST_RST = 1'b0;

    // ------------------------------------------------------------
    // basic_status field positions, fixed values and reset values
    // ------------------------------------------------------------
    localparam int STS_ABILITY_LSB = 11;
    localparam logic [4:0] STS_ABILITY_VAL = 5'h0F; // four-pair 0, the other four 1
    localparam int STS_PRE_SUPP_BIT = 6;
    localparam int STS_NEG_DONE_BIT = 5;
    localparam int STS_REM_FAULT_BIT = 4;
    localparam logic STS_NEG_DONE_RST = 1'b0;
    localparam logic STS_REM_FAULT_RST = 1'b0;
    localparam logic STS_PRE_SUPP_RST = 1'b1;

    // ------------------------------------------------------------
    // collision test timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int BIT_TIME_PS = 10000; // one bit time at 100 Mb/s
    localparam int COL_ON_MAX_BT = 512;
    localparam int COL_OFF_MAX_BT = 4;
    // longest times round down to whole cycles
    localparam int COL_ON_MAX_CYC = (COL_ON_MAX_BT * BIT_TIME_PS) / CLK_PERIOD_PS;
    localparam int COL_OFF_MAX_CYC = (COL_OFF_MAX_BT * BIT_TIME_PS) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // management register access, one cycle strobes
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pcs_req_s;

endpackage

// File: verif/pcs_mgmt_model.sv
// management controller model: issues register reads and writes on the strobe port
// assumes the register bank answers a read one cycle after the request edge
`timescale 1ns/100ps
module pcs_mgmt_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in,
    output pcs_pkg::pcs_req_s req_out
);
    int since_rst = 0;

    // cycles since reset, standing in for the preamble sent before any frame
    always @(posedge clk_in) begin
        since_rst <= srst_in ? 0 : since_rst + 1;
    end

    initial req_out = '0;

    // one access, answer taken at the edge after the request, then an idle edge
    task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wd,
                          output logic [15:0] rd, output logic rv);
        while (since_rst < 32) @(posedge clk_in);
        @(posedge clk_in);
        #1 req_out = '{wr: wr, rd: !wr, addr: addr, wdata: wd};
        @(posedge clk_in);
        #1 req_out = '0;
        rd = rdata_in;
        rv = rvalid_in;
        @(posedge clk_in);
        #1;
    endtask
endmodule // pcs_mgmt_model

// File: verif/phy_control_status_regs_tb_top.sv
// self-checking bench for the control/status register bank
// assumes pcs_mgmt_model drives the strobe port; other inputs driven here
`timescale 1ns/100ps
module phy_control_status_regs_tb_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic neg_done_in = 1'b0, partner_fault_in = 1'b0, mode_pre_supp_in = 1'b1;
    logic restart_ack_in = 1'b0, negotiated_full_in = 1'b0, tx_en_in = 1'b0;
    pcs_pkg::pcs_req_s req;
    logic [15:0] rdata, rd, wd;
    logic rvalid, reneg, aneg, fdx, col, rv;
    int n_fail = 0, checks = 0, n;
    localparam logic [4:0] CTL = pcs_pkg::BASIC_CONTROL_IDX;
    localparam logic [4:0] STS = pcs_pkg::BASIC_STATUS_IDX;

    always #4 clk_in = ~clk_in;

    pcs_ctl_regs dut (.clk_in(clk_in), .srst_in(srst_in), .req_in(req), .neg_done_in(neg_done_in),
        .partner_fault_in(partner_fault_in), .mode_pre_supp_in(mode_pre_supp_in),
        .restart_ack_in(restart_ack_in), .negotiated_full_in(negotiated_full_in), .tx_en_in(tx_en_in),
        .rdata_out(rdata), .rvalid_out(rvalid), .renegotiate_out(reneg), .aneg_enable_out(aneg),
        .full_duplex_out(fdx), .col_out(col));
    pcs_mgmt_model mgmt (.clk_in(clk_in), .srst_in(srst_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .req_out(req));

    // ----------------------------------------------------------------
    // expectations and access helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] sts_exp(input logic pre, input logic done, input logic flt);
        sts_exp = 16'h0000;
        sts_exp[pcs_pkg::STS_ABILITY_LSB +: 5] = pcs_pkg::STS_ABILITY_VAL;
        sts_exp[pcs_pkg::STS_PRE_SUPP_BIT] = pre;
        sts_exp[pcs_pkg::STS_NEG_DONE_BIT] = done;
        sts_exp[pcs_pkg::STS_REM_FAULT_BIT] = flt;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdreg(input logic [4:0] a);
        mgmt.access(1'b0, a, 16'h0000, rd, rv);
        chk("read answer", 16'h0001, {15'h0000, rv});
    endtask

    task automatic wrreg(input logic [4:0] a, input logic [15:0] d);
        mgmt.access(1'b1, a, d, rd, rv);
        chk("write answer", 16'h0000, {15'h0000, rv});
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(79115));
        repeat (20) @(posedge clk_in);
        #1 srst_in = 1'b0;
        rdreg(CTL);
        chk("control reset", 16'h1000, rd);
        rdreg(STS);
        chk("status reset", sts_exp(1'b1, 1'b0, 1'b0), rd & 16'hFFF0);
        rdreg(5'h05);
        chk("unmapped", 16'h0000, rd);
        // random levels; restart bit kept clear since its ack is tested on its own
        for (int i = 0; i < 24; i++) begin
            {neg_done_in, mode_pre_supp_in, negotiated_full_in} = 3'($urandom);
            wd = 16'($urandom) & 16'hFDFF;
            wrreg(STS, ~wd);
            wrreg(CTL, wd);
            rdreg(CTL);
            chk("control", wd & 16'h1180, rd);
            chk("aneg", {15'h0000, wd[12]}, {15'h0000, aneg});
            chk("duplex", {15'h0000, wd[12] ? negotiated_full_in : wd[8]}, {15'h0000, fdx});
            rdreg(STS);
            chk("status", sts_exp(mode_pre_supp_in, neg_done_in, 1'b0), rd & 16'hFFF0);
        end
        wrreg(CTL, 16'h0200);
        chk("restart out", 16'h0001, {15'h0000, reneg});
        restart_ack_in = 1'b1;
        @(posedge clk_in);
        #1 restart_ack_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 rdreg(CTL);
        chk("restart cleared", 16'h0000, rd | {15'h0000, reneg});
        // fault pulse ends before the read is issued: only the latch can report it
        partner_fault_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 partner_fault_in = 1'b0;
        rdreg(STS);
        chk("fault latched", 16'h0010, rd & 16'h0010);
        rdreg(STS);
        chk("fault cleared", 16'h0000, rd & 16'h0010);
        wrreg(CTL, 16'h0080);
        tx_en_in = 1'b1;
        n = 0;
        while (col !== 1'b1 && n < pcs_pkg::COL_ON_MAX_CYC) begin
            @(posedge clk_in);
            #1 n++;
        end
        chk("col on", 16'h0001, {15'h0000, col});
        tx_en_in = 1'b0;
        n = 0;
        while (col !== 1'b0 && n < pcs_pkg::COL_OFF_MAX_CYC) begin
            @(posedge clk_in);
            #1 n++;
        end
        chk("col off", 16'h0000, {15'h0000, col});
        wrreg(CTL, 16'h0000);
        tx_en_in = 1'b1;
        repeat (8) @(posedge clk_in);
        #1 chk("col normal", 16'h0000, {15'h0000, col});
        tx_en_in = 1'b0;
        // mid-run reset: outputs and control word must return to their defaults
        srst_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 srst_in = 1'b0;
        chk("outputs after reset", 16'h0001, {11'h000, rvalid, reneg, fdx, col, aneg});
        chk("rdata after reset", 16'h0000, rdata);
        rdreg(CTL);
        chk("control after reset", 16'h1000, rd);
        complete_run();
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        n_fail++;
        $display("MISMATCH watchdog expected finish seen timeout");
        complete_run();
    end
endmodule // phy_control_status_regs_tb_top
